// ### hw/decode_pkg.sv
// Constants shared by the PCI target address decoder
package decode_pkg;
   // ------------------------------------------------------------
   // Register byte addresses
   // ------------------------------------------------------------
   localparam logic [3:0] CTRL_OFS   = 4'h0;
   localparam logic [3:0] BUSCFG_OFS = 4'h4;
   localparam logic [3:0] STATUS_OFS = 4'h8;
   localparam logic [3:0] COUNT_OFS  = 4'hc;
   // ------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------
   localparam int CTRL_IO_EN_BIT  = 0;
   localparam int CTRL_MEM_EN_BIT = 1;
   localparam int CTRL_UNIQUE_BIT = 2;
   localparam int CTRL_MODE_LSB   = 4;
   localparam logic [6:0] CTRL_RESET = 7'h00;
   // ------------------------------------------------------------
   // Local bus configuration fields
   // ------------------------------------------------------------
   localparam int BUSCFG_SIZE_LSB = 0;
   localparam int BUSCFG_LOW_LSB  = 3;
   // Default: 32-byte block, decode from bit 3, same map as UARTs
   localparam logic [2:0] BUSCFG_SIZE_RESET = 3'h4;
   localparam logic [3:0] BUSCFG_LOW_RESET  = 4'h3;
   // ------------------------------------------------------------
   // Device modes with the local bus bridge
   // ------------------------------------------------------------
   localparam logic [2:0] MODE_LB_A = 3'h0;
   localparam logic [2:0] MODE_LB_B = 3'h3;
   localparam logic [2:0] MODE_LB_C = 3'h4;
   // ------------------------------------------------------------
   // Window sizes and address fields
   // ------------------------------------------------------------
   localparam logic [11:0] IO_SHARED_LIMIT = 12'h020;
   localparam logic [11:0] IO_UNIQUE_LIMIT = 12'h008;
   localparam int MEM_REGION_BIT = 7;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
endpackage

// ### hw/pci_uart_localbus_decode.sv
// PCI target decoder: UART register sets and 8-bit local bus
`timescale 1ns/1ps
// What this block does
// - Shared mode: function 0 claims 32-byte I/O BAR0 and 4K memory BAR1.
// - Shared I/O: offset n*8+r reaches register r of UART n.
// - Memory: register r of UART n sits at n*20h plus r*4.
// - Only low memory bits decoded, so UART sets alias across 4K.
// - Unique mode: BAR0..3 are 8-byte I/O windows, BAR5 4K memory.
// - Unique I/O: offsets 0..7 select that UART's registers directly.
// - Unique BAR5: bit 7 low reaches UARTs, high reaches local registers.
// - Host enables I/O and memory spaces; no claim while disabled.
// - Function 1 bridges only in modes 000, 011 and 100.
// - Function 1 I/O block is 4 to 256 bytes with configurable decode bit.
// - 256-byte block drives address outputs from offset bits 7..0.
// - Smaller block forces address outputs above its range to zero.
// - Two bits from decode bit k choose one of four selects.
// - Decode bit at the block top yields only selects 0 and 1.
// - Decode bit beyond the block gives select 0 only; software keeps k<=8.
// - Default configuration matches the shared UART I/O map.
// - Memory access drives bits 9..2 out and decodes bits 11..10.
module pci_uart_localbus_decode
   import decode_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   // AXI4-Lite register slave
   input  wire logic [3:0]  s_awaddr,
   input  wire logic        s_awvalid,
   output logic             s_awready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   input  wire logic        s_wvalid,
   output logic             s_wready,
   output logic [1:0]       s_bresp,
   output logic             s_bvalid,
   input  wire logic        s_bready,
   input  wire logic [3:0]  s_araddr,
   input  wire logic        s_arvalid,
   output logic             s_arready,
   output logic [31:0]      s_rdata,
   output logic [1:0]       s_rresp,
   output logic             s_rvalid,
   input  wire logic        s_rready,
   // PCI access phase from the target core
   input  wire logic        req_valid,
   input  wire logic        req_func,
   input  wire logic        req_is_mem,
   input  wire logic [2:0]  req_bar,
   input  wire logic [11:0] req_offset,
   // Decode results
   output logic             claim,
   output logic             uart_hit,
   output logic [1:0]       uart_index,
   output logic [2:0]       uart_reg,
   output logic             lcfg_hit,
   output logic [7:0]       lcfg_offset,
   output logic [7:0]       periph_addr_out,
   output logic             periph_select0_n,
   output logic             periph_select1_n,
   output logic             periph_select2_n,
   output logic             periph_select3_n
);
   // ------------------------------------------------------------
   // Register bus state
   // ------------------------------------------------------------
   logic        awready_q, awready_d, wready_q, wready_d;
   logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic [3:0]  aw_addr_q, aw_addr_d;
   logic [7:0]  w_byte_q, w_byte_d;
   logic        w_lane_q, w_lane_d;
   logic        bvalid_q, bvalid_d, arready_q, arready_d;
   logic        rvalid_q, rvalid_d;
   logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic [6:0]  ctrl_q, ctrl_d;
   logic [2:0]  size_q, size_d;
   logic [3:0]  low_q, low_d;
   logic [15:0] count_q, count_d;
   logic        io_en, mem_en, unique_bar;
   logic [2:0]  dev_mode;

   assign io_en      = ctrl_q[CTRL_IO_EN_BIT];
   assign mem_en     = ctrl_q[CTRL_MEM_EN_BIT];
   assign unique_bar = ctrl_q[CTRL_UNIQUE_BIT];
   assign dev_mode   = ctrl_q[CTRL_MODE_LSB +: 3];

   always_comb begin
      aw_have_d = aw_have_q;
      aw_addr_d = aw_addr_q;
      w_have_d  = w_have_q;
      w_byte_d  = w_byte_q;
      w_lane_d  = w_lane_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      rvalid_d  = rvalid_q;
      rdata_d   = rdata_q;
      rresp_d   = rresp_q;
      ctrl_d    = ctrl_q;
      size_d    = size_q;
      low_d     = low_q;
      if (s_awvalid && awready_q) begin
         aw_have_d = 1'b1;
         aw_addr_d = s_awaddr;
      end
      if (s_wvalid && wready_q) begin
         w_have_d = 1'b1;
         w_byte_d = s_wdata[7:0];
         w_lane_d = s_wstrb[0];
      end
      if (bvalid_q && s_bready) begin
         bvalid_d = 1'b0;
      end
      // Address and data may arrive in either order
      if (aw_have_d && w_have_d && !bvalid_d) begin
         aw_have_d = 1'b0;
         w_have_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = RESP_OKAY;
         case (aw_addr_d)
            CTRL_OFS: begin
               if (w_lane_d) begin
                  ctrl_d = w_byte_d[6:0];
               end
            end
            BUSCFG_OFS: begin
               if (w_lane_d) begin
                  size_d = w_byte_d[BUSCFG_SIZE_LSB +: 3];
                  low_d  = w_byte_d[BUSCFG_LOW_LSB +: 4];
               end
            end
            STATUS_OFS, COUNT_OFS: begin
               bresp_d = RESP_OKAY;
            end
            default: begin
               bresp_d = RESP_SLVERR;
            end
         endcase
      end
      if (rvalid_q && s_rready) begin
         rvalid_d = 1'b0;
      end
      if (s_arvalid && arready_q) begin
         rvalid_d = 1'b1;
         rresp_d  = RESP_OKAY;
         case (s_araddr)
            CTRL_OFS:   rdata_d = {25'h0, ctrl_q};
            BUSCFG_OFS: rdata_d = {25'h0, low_q, size_q};
            STATUS_OFS: rdata_d = {16'h0, claim, uart_hit, uart_index,
                                   uart_reg, lcfg_hit, periph_select3_n,
                                   periph_select2_n, periph_select1_n,
                                   periph_select0_n, 4'h0};
            COUNT_OFS:  rdata_d = {16'h0, count_q};
            default: begin
               rdata_d = 32'h0000_0000;
               rresp_d = RESP_SLVERR;
            end
         endcase
      end
      // One write and one read in flight, no more
      awready_d = !aw_have_d && !bvalid_d;
      wready_d  = !w_have_d && !bvalid_d;
      arready_d = !rvalid_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         aw_have_q <= 1'b0;
         aw_addr_q <= 4'h0;
         w_have_q  <= 1'b0;
         w_byte_q  <= 8'h00;
         w_lane_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= RESP_OKAY;
         ctrl_q    <= CTRL_RESET;
         size_q    <= BUSCFG_SIZE_RESET;
         low_q     <= BUSCFG_LOW_RESET;
      end else if (ce) begin
         awready_q <= awready_d;
         wready_q  <= wready_d;
         aw_have_q <= aw_have_d;
         aw_addr_q <= aw_addr_d;
         w_have_q  <= w_have_d;
         w_byte_q  <= w_byte_d;
         w_lane_q  <= w_lane_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         arready_q <= arready_d;
         rvalid_q  <= rvalid_d;
         rdata_q   <= rdata_d;
         rresp_q   <= rresp_d;
         ctrl_q    <= ctrl_d;
         size_q    <= size_d;
         low_q     <= low_d;
      end
   end

   assign s_awready = awready_q;
   assign s_wready  = wready_q;
   assign s_bvalid  = bvalid_q;
   assign s_bresp   = bresp_q;
   assign s_arready = arready_q;
   assign s_rvalid  = rvalid_q;
   assign s_rdata   = rdata_q;
   assign s_rresp   = rresp_q;

   // ------------------------------------------------------------
   // Access decode
   // ------------------------------------------------------------
   logic        claim_q, uhit_q, lhit_q;
   logic [1:0]  uidx_q;
   logic [2:0]  ureg_q;
   logic [7:0]  loff_q, paddr_q;
   logic [3:0]  sel_n_q;
   logic        claim_d, uhit_d, lhit_d;
   logic [1:0]  uidx_d;
   logic [2:0]  ureg_d;
   logic [7:0]  loff_d, paddr_d;
   logic [3:0]  sel_n_d;
   logic [8:0]  lb_span;
   logic [7:0]  lb_mask, lb_addr;
   logic [15:0] lb_ext;
   logic [1:0]  lb_sel;
   logic        lb_mode, io_ok, mem_ok;

   // Size code 1..7 gives 4..256 bytes; 0 is taken as 256
   assign lb_span = 9'h001 << (4'(size_q) + 4'h1);
   assign lb_mask = (size_q == 3'h0) ? 8'hff : 8'(lb_span - 9'h001);
   // address lines above the block forced low
   assign lb_addr = req_offset[7:0] & lb_mask;
   // bits beyond range read as zero
   assign lb_ext  = {8'h00, lb_addr};
   assign lb_sel  = 2'(lb_ext >> low_q);
   // bridge only in local bus modes
   assign lb_mode = (dev_mode == MODE_LB_A) || (dev_mode == MODE_LB_B)
                    || (dev_mode == MODE_LB_C);
   assign io_ok   = req_valid && !req_is_mem && io_en;
   assign mem_ok  = req_valid && req_is_mem && mem_en;

   always_comb begin
      claim_d = 1'b0;
      uhit_d  = 1'b0;
      lhit_d  = 1'b0;
      uidx_d  = 2'h0;
      ureg_d  = 3'h0;
      loff_d  = 8'h00;
      paddr_d = 8'h00;
      sel_n_d = 4'hf;
      count_d = count_q;
      if (!req_func) begin
         if (io_ok && !unique_bar && req_bar == 3'h0
             && req_offset < IO_SHARED_LIMIT) begin
            uhit_d = 1'b1;
            uidx_d = req_offset[4:3];
            ureg_d = req_offset[2:0];
         end else if (io_ok && unique_bar && req_bar < 3'h4
                      && req_offset < IO_UNIQUE_LIMIT) begin
            uhit_d = 1'b1;
            uidx_d = req_bar[1:0];
            ureg_d = req_offset[2:0];
         end else if (io_ok && req_bar == (unique_bar ? 3'h4 : 3'h2)) begin
            lhit_d = 1'b1;
            loff_d = req_offset[7:0];
         end else if (mem_ok && !unique_bar && req_bar == 3'h1) begin
            uhit_d = 1'b1;
            uidx_d = req_offset[6:5];
            ureg_d = req_offset[4:2];
         end else if (mem_ok && unique_bar && req_bar == 3'h5) begin
            if (req_offset[MEM_REGION_BIT]) begin
               lhit_d = 1'b1;
               loff_d = {1'b0, req_offset[6:0]};
            end else begin
               uhit_d = 1'b1;
               uidx_d = req_offset[6:5];
               ureg_d = req_offset[4:2];
            end
         end else if (mem_ok && !unique_bar && req_bar == 3'h3) begin
            lhit_d = 1'b1;
            loff_d = req_offset[7:0];
         end
      end else begin
         if (io_ok && lb_mode && req_bar == 3'h0
             && (req_offset & ~{4'h0, lb_mask}) == 12'h000) begin
            claim_d = 1'b1;
            paddr_d = lb_addr;
            sel_n_d = ~(4'h1 << lb_sel);
         // memory map ignores the decode bit
         end else if (mem_ok && lb_mode && req_bar == 3'h1) begin
            claim_d = 1'b1;
            paddr_d = req_offset[9:2];
            sel_n_d = ~(4'h1 << req_offset[11:10]);
         end else if (io_ok && req_bar == 3'h2) begin
            lhit_d = 1'b1;
            loff_d = req_offset[7:0];
         end else if (mem_ok && req_bar == 3'h3) begin
            lhit_d = 1'b1;
            loff_d = req_offset[7:0];
         end
      end
      claim_d = claim_d || uhit_d || lhit_d;
      if (claim_d) begin
         count_d = count_q + 16'h0001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         claim_q <= 1'b0;
         uhit_q  <= 1'b0;
         lhit_q  <= 1'b0;
         uidx_q  <= 2'h0;
         ureg_q  <= 3'h0;
         loff_q  <= 8'h00;
         paddr_q <= 8'h00;
         sel_n_q <= 4'hf;
         count_q <= COUNT_RESET;
      end else if (ce) begin
         claim_q <= claim_d;
         uhit_q  <= uhit_d;
         lhit_q  <= lhit_d;
         uidx_q  <= uidx_d;
         ureg_q  <= ureg_d;
         loff_q  <= loff_d;
         paddr_q <= paddr_d;
         sel_n_q <= sel_n_d;
         count_q <= count_d;
      end
   end

   assign claim            = claim_q;
   assign uart_hit         = uhit_q;
   assign uart_index       = uidx_q;
   assign uart_reg         = ureg_q;
   assign lcfg_hit         = lhit_q;
   assign lcfg_offset      = loff_q;
   assign periph_addr_out  = paddr_q;
   assign periph_select0_n = sel_n_q[0];
   assign periph_select1_n = sel_n_q[1];
   assign periph_select2_n = sel_n_q[2];
   assign periph_select3_n = sel_n_q[3];

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sel_onehot_a: assert property ($onehot0(~sel_n_q))
      else $error("more than one peripheral select asserted");
   sel_idle_a: assert property (
      ce && !req_valid |=> sel_n_q == 4'hf && !claim_q)
      else $error("select asserted with no access");
   io_gate_a: assert property (
      ce && req_valid && !req_is_mem && !io_en |=> !claim_q)
      else $error("I/O access claimed while I/O space disabled");
   mem_gate_a: assert property (
      ce && req_valid && req_is_mem && !mem_en |=> !claim_q)
      else $error("memory access claimed while memory disabled");
   mode_gate_a: assert property (
      ce && req_valid && req_func && !lb_mode |=> sel_n_q == 4'hf)
      else $error("local bus used outside bridge modes");
   uart_io_a: assert property (
      ce && io_ok && !req_func && !unique_bar && req_bar == 3'h0
      && req_offset < IO_SHARED_LIMIT
      |=> uhit_q && uidx_q == $past(req_offset[4:3])
          && ureg_q == $past(req_offset[2:0]))
      else $error("shared I/O UART decode wrong");
   uart_mem_a: assert property (
      ce && mem_ok && !req_func && !unique_bar && req_bar == 3'h1
      |=> uhit_q && uidx_q == $past(req_offset[6:5])
          && ureg_q == $past(req_offset[4:2]))
      else $error("memory UART decode wrong");
   bar5_split_a: assert property (
      ce && mem_ok && !req_func && unique_bar && req_bar == 3'h5
      |=> lhit_q == $past(req_offset[7]) && uhit_q != lhit_q)
      else $error("BAR5 region select wrong");
   lb_mem_a: assert property (
      ce && mem_ok && req_func && lb_mode && req_bar == 3'h1
      |=> periph_addr_out == $past(req_offset[9:2])
          && sel_n_q == ~(4'h1 << $past(req_offset[11:10])))
      else $error("local bus memory decode wrong");
   lb_zero_a: assert property (
      ce && io_ok && req_func |=> (paddr_q & ~$past(lb_mask)) == 8'h00)
      else $error("address line above block range driven high");
   wr_resp_a: assert property (
      ce && s_awvalid && awready_q && s_wvalid && wready_q |=> bvalid_q)
      else $error("write response missing");
endmodule

// ### tb/periph_model.sv
// Behavioural model of the peripheral chips on the 8-bit local bus
`timescale 1ns/1ps
module periph_model (
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Local bus from the decoder
   input  wire logic [7:0] addr,
   input  wire logic       sel0_n,
   input  wire logic       sel1_n,
   input  wire logic       sel2_n,
   input  wire logic       sel3_n,
   // Observation for the bench
   output logic [15:0]     hits,
   output logic            clash
);
   logic [3:0] sel;
   assign sel = ~{sel3_n, sel2_n, sel1_n, sel0_n};
   // Cleared in reset: selects are unknown until the first edge
   always @(posedge aclk) begin
      if (aresetn !== 1'b1) begin
         hits <= 16'h0000;
         clash <= 1'b0;
      end else begin
         if (sel !== 4'h0) begin
            hits <= hits + 16'h0001;
         end
         if ($countones(sel) > 1 || (sel === 4'h0 && addr !== 8'h00)) begin
            clash <= 1'b1;
         end
      end
   end
endmodule

// ### tb/tb_pci_uart_localbus_decode.sv
// Self-checking testbench for the PCI target address decoder
`timescale 1ns/1ps
module tb_pci_uart_localbus_decode
   import decode_pkg::*;
;
   logic        aclk, aresetn;
   logic [3:0]  s_awaddr, s_araddr, s_wstrb, sel_n;
   logic [31:0] s_wdata, s_rdata;
   logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
   logic        s_arvalid, s_arready, s_rvalid, s_rready;
   logic [1:0]  s_bresp, s_rresp, uart_index;
   logic        req_valid, req_func, req_is_mem, claim, uart_hit, lcfg_hit;
   logic [2:0]  req_bar, uart_reg;
   logic [11:0] req_offset;
   logic [7:0]  lcfg_offset, periph_addr_out;
   logic [15:0] lb_hits;
   logic        lb_clash, ce;
   int          miscompares, total_checks, exp_cnt, exp_lb;
   localparam logic [27:0] E_NONE = {8'h00, 2'b00, 5'h00, 1'b0, 4'hf, 8'h00};
   localparam logic [27:0] E_LCFG = {8'h00, 2'b10, 5'h00, 1'b1, 4'hf, 8'h00};

   pci_uart_localbus_decode dut_u (
      .aclk(aclk), .aresetn(aresetn), .ce(ce),
      .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
      .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
      .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
      .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
      .s_rvalid(s_rvalid), .s_rready(s_rready), .req_valid(req_valid),
      .req_func(req_func), .req_is_mem(req_is_mem), .req_bar(req_bar),
      .req_offset(req_offset), .claim(claim), .uart_hit(uart_hit),
      .uart_index(uart_index), .uart_reg(uart_reg), .lcfg_hit(lcfg_hit),
      .lcfg_offset(lcfg_offset), .periph_addr_out(periph_addr_out),
      .periph_select0_n(sel_n[0]), .periph_select1_n(sel_n[1]),
      .periph_select2_n(sel_n[2]), .periph_select3_n(sel_n[3]));

   periph_model pm_u (
      .aclk(aclk), .aresetn(aresetn), .addr(periph_addr_out),
      .sel0_n(sel_n[0]), .sel1_n(sel_n[1]), .sel2_n(sel_n[2]),
      .sel3_n(sel_n[3]), .hits(lb_hits), .clash(lb_clash));

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic final_report();
      if (miscompares == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] st, input logic [1:0] er);
      bit aw, w;
      s_awaddr <= a;
      s_wdata <= d;
      s_wstrb <= st;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      aw = 1'b1;
      w = 1'b1;
      while (aw || w) begin
         @(posedge aclk);
         if (aw && s_awready === 1'b1) begin
            aw = 1'b0;
            s_awvalid <= 1'b0;
         end
         if (w && s_wready === 1'b1) begin
            w = 1'b0;
            s_wvalid <= 1'b0;
         end
      end
      s_bready <= 1'b1;
      do begin
         @(posedge aclk);
      end while (s_bvalid !== 1'b1);
      s_bready <= 1'b0;
      chk("bresp", {30'h0, s_bresp}, {30'h0, er});
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
      end while (s_arready !== 1'b1);
      s_arvalid <= 1'b0;
      s_rready <= 1'b1;
      do begin
         @(posedge aclk);
      end while (s_rvalid !== 1'b1);
      s_rready <= 1'b0;
      chk("rdata", s_rdata, ed);
      chk("rresp", {30'h0, s_rresp}, {30'h0, er});
   endtask

   function automatic logic [27:0] eu(input int n, input int r);
      return {8'h00, 2'b11, n[1:0], r[2:0], 1'b0, 4'hf, 8'h00};
   endfunction

   function automatic logic [27:0] es(input int s, input logic [7:0] a);
      return {8'h00, 2'b10, 5'h00, 1'b0, ~(4'h1 << s), a};
   endfunction

   // Decode result lands one edge after the request; then idle
   task automatic acc(input logic f, input logic m, input logic [2:0] b,
                      input logic [11:0] o, input logic [27:0] e);
      logic [27:0] s;
      req_func <= f;
      req_is_mem <= m;
      req_bar <= b;
      req_offset <= o;
      req_valid <= 1'b1;
      @(posedge aclk);
      req_valid <= 1'b0;
      @(posedge aclk);
      s = {lcfg_offset, claim, uart_hit, uart_index, uart_reg, lcfg_hit,
           sel_n, periph_addr_out};
      if (e[18] !== 1'b1) s[17:13] = 5'h00;
      chk("decode", 32'(s), 32'(e));
      exp_cnt += e[19];
      exp_lb += (e[11:8] != 4'hf);
      @(posedge aclk);
      chk("idle", {19'h0, claim, sel_n, periph_addr_out}, 32'hf00);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      rd(CTRL_OFS, 32'h0, RESP_OKAY);
      rd(BUSCFG_OFS, 32'h1c, RESP_OKAY);
      rd(STATUS_OFS, 32'hf0, RESP_OKAY);
      rd(4'h6, 32'h0, RESP_SLVERR);
      wr(4'h6, 32'h1, 4'hf, RESP_SLVERR);
      wr(COUNT_OFS, 32'h1234, 4'hf, RESP_OKAY);
      rd(COUNT_OFS, 32'h0, RESP_OKAY);
      wr(BUSCFG_OFS, 32'h7f, 4'he, RESP_OKAY);
      rd(BUSCFG_OFS, 32'h1c, RESP_OKAY);
   endtask

   task automatic t_off();
      acc(1'b0, 1'b0, 3'h0, 12'h001, E_NONE);
      acc(1'b1, 1'b0, 3'h0, 12'h001, E_NONE);
      wr(CTRL_OFS, 32'h1, 4'hf, RESP_OKAY);
      acc(1'b0, 1'b1, 3'h1, 12'h004, E_NONE);
      acc(1'b0, 1'b0, 3'h0, 12'h001, eu(0, 1));
   endtask

   task automatic t_shared();
      wr(CTRL_OFS, 32'h3, 4'hf, RESP_OKAY);
      for (int n = 0; n < 4; n++) begin
         for (int r = 0; r < 8; r++) begin
            acc(1'b0, 1'b0, 3'h0, 12'(n * 8 + r), eu(n, r));
            acc(1'b0, 1'b1, 3'h1, 12'(n * 32 + r * 4), eu(n, r));
            acc(1'b0, 1'b1, 3'h1, 12'(3968 + n * 32 + r * 4), eu(n, r));
         end
      end
      acc(1'b0, 1'b0, 3'h0, 12'h020, E_NONE);
      acc(1'b0, 1'b0, 3'h2, 12'h05a, {8'h5a, E_LCFG[19:0]});
      acc(1'b0, 1'b1, 3'h3, 12'h0c3, {8'hc3, E_LCFG[19:0]});
   endtask

   task automatic t_unique();
      wr(CTRL_OFS, 32'h7, 4'hf, RESP_OKAY);
      for (int b = 0; b < 4; b++) begin
         for (int r = 0; r < 8; r++) begin
            acc(1'b0, 1'b0, 3'(b), 12'(r), eu(b, r));
         end
      end
      acc(1'b0, 1'b0, 3'h3, 12'h008, E_NONE);
      acc(1'b0, 1'b1, 3'h1, 12'h000, E_NONE);
      acc(1'b0, 1'b1, 3'h5, 12'h07c, eu(3, 7));
      acc(1'b0, 1'b1, 3'h5, 12'h0ab, {8'h2b, E_LCFG[19:0]});
      acc(1'b0, 1'b0, 3'h4, 12'h000, E_LCFG);
   endtask

   task automatic t_modes();
      for (int md = 0; md < 8; md++) begin
         wr(CTRL_OFS, 32'(3 + md * 16), 4'hf, RESP_OKAY);
         acc(1'b1, 1'b0, 3'h0, 12'h00a,
             (md == 0 || md == 3 || md == 4) ? es(1, 8'h0a) : E_NONE);
      end
      wr(CTRL_OFS, 32'h3, 4'hf, RESP_OKAY);
   endtask

   // Claimable access while frozen must leave every output idle
   task automatic t_ce();
      ce <= 1'b0;
      acc(1'b1, 1'b0, 3'h0, 12'h00a, E_NONE);
      ce <= 1'b1;
   endtask

   task automatic t_lbio();
      for (int s = 0; s < 4; s++) begin
         acc(1'b1, 1'b0, 3'h0, 12'(s * 8 + 7), es(s, 8'(s * 8 + 7)));
      end
      acc(1'b1, 1'b0, 3'h0, 12'h020, E_NONE);
      wr(BUSCFG_OFS, 32'h37, 4'h1, RESP_OKAY);
      acc(1'b1, 1'b0, 3'h0, 12'h0ab, es(2, 8'hab));
      wr(BUSCFG_OFS, 32'h13, 4'h1, RESP_OKAY);
      acc(1'b1, 1'b0, 3'h0, 12'h00f, es(3, 8'h0f));
      acc(1'b1, 1'b0, 3'h0, 12'h010, E_NONE);
      wr(BUSCFG_OFS, 32'h24, 4'h1, RESP_OKAY);
      acc(1'b1, 1'b0, 3'h0, 12'h01f, es(1, 8'h1f));
      acc(1'b1, 1'b0, 3'h0, 12'h00f, es(0, 8'h0f));
      wr(BUSCFG_OFS, 32'h2c, 4'h1, RESP_OKAY);
      acc(1'b1, 1'b0, 3'h0, 12'h01f, es(0, 8'h1f));
      acc(1'b1, 1'b0, 3'h0, 12'h010, es(0, 8'h10));
      wr(BUSCFG_OFS, 32'h01, 4'h1, RESP_OKAY);
      acc(1'b1, 1'b0, 3'h0, 12'h003, es(3, 8'h03));
      acc(1'b1, 1'b0, 3'h0, 12'h004, E_NONE);
      wr(BUSCFG_OFS, 32'h00, 4'h1, RESP_OKAY);
      acc(1'b1, 1'b0, 3'h0, 12'h0ff, es(3, 8'hff));
      acc(1'b1, 1'b1, 3'h1, 12'habc, es(2, 8'haf));
      acc(1'b1, 1'b1, 3'h1, 12'h3fc, es(0, 8'hff));
      acc(1'b1, 1'b0, 3'h2, 12'h000, E_LCFG);
   endtask

   initial begin
      {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
      {s_awaddr, s_araddr, s_wstrb, s_wdata} = '0;
      {req_valid, req_func, req_is_mem, req_bar, req_offset} = '0;
      {miscompares, total_checks, exp_cnt, exp_lb} = '0;
      ce = 1'b1;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs();
      t_off();
      t_shared();
      t_unique();
      t_modes();
      t_ce();
      t_lbio();
      rd(COUNT_OFS, 32'(exp_cnt), RESP_OKAY);
      chk("lb hits", 32'(lb_hits), 32'(exp_lb));
      chk("lb clash", 32'(lb_clash), 32'h0);
      final_report();
   end

   // Whole run needs about 560 cycles
   initial begin
      repeat (6000) @(posedge aclk);
      miscompares++;
      final_report();
   end
endmodule
